// ---- logic/ibf_fetch.sv ----
// Parameter-block fetch and mode control for the network controller.
// Assumes a word-wide bus-master read port and same-clock MAC datapath.
//
// Behaviour
// - Setup request makes the block fetch the parameter block before using it.
// - After the full fetch set setup-done flag; interrupt when enable is 1.
// - Words read upward: mode, station, hash, rx ring, tx ring.
// - Mode bit 15 makes the receiver accept every packet.
// - Mode bits 14 to 8 are written and read as zero.
// - Mode bit 7 selects modified back-off; cleared by reset or stop.
// - Loop bit 2 and inside bit 6 select none, external or internal wrap.
// - Internal loopback feeds transmit into receive, ignores the network.
// - External loopback transmits to the medium and still receives.
// - Bit 5 gives one attempt; a collision reports a retry error.
// - Bit 4 in internal loopback forces a collision; 16 attempts, retry error.
// - Bit 3 clear appends transmit CRC; set gives CRC logic to receiver.
// - Per-packet append flag forces transmit CRC despite bit 3.
// - Loopback with transmit CRC: generate, no receive check, store CRC.
// - Loopback without transmit CRC: software supplies CRC, receiver checks.
// - Loopback frames 8 to 32 bytes, receive up to 36 with transmit CRC, else 32, no short filter.
// - Loopback sends only full transmit FIFO; receive drains after end.
// - Bit 1 keeps off the transmit ring and clears transmitter running.
// - Bit 0 rejects packets, keeps off receive ring, clears receiver running.
// - Base address is 24 bits from low word (bit 0 zero) and high byte.
`timescale 1ns/1ps
module ibf_fetch
  import ibf_pkg::*;
(
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_N,
  input  wire logic                 STOP_CMD,
  input  wire logic                 SETUP_REQ,
  input  wire logic                 RUN_REQ,
  input  wire logic                 IRQ_ENABLE,
  input  wire logic                 DONE_CLEAR,
  input  wire logic [15:0]          PARAM_BASE_LOW_REG,
  input  wire logic [7:0]           PARAM_BASE_HIGH_REG,
  output ibf_pkg::ibf_dma_req_t     DMA_REQ,
  input  wire logic                 DMA_ACK,
  input  wire logic [15:0]          DMA_RDATA,
  output logic [15:0]               OPERATING_MODE_WORD,
  output ibf_pkg::ibf_mode_t        MODE,
  output ibf_pkg::ibf_params_t      PARAMS,
  output logic                      SETUP_DONE_FLAG,
  output logic                      IRQ_N,
  output logic                      SETUP_BUSY,
  output logic                      TRANSMITTER_RUNNING,
  output logic                      RECEIVER_RUNNING,
  output logic                      TX_RING_ALLOWED,
  output logic                      RX_RING_ALLOWED,
  input  wire logic                 TX_APPEND_FCS,
  output logic                      TX_CRC_APPEND,
  output logic                      RX_CRC_CHECK,
  output logic                      RX_NET_ENABLE,
  output logic                      TX_TO_RX_WRAP,
  output logic                      RX_ACCEPT_ALL,
  output logic                      RX_SHORT_FILTER,
  output logic                      TX_WAIT_FULL_FRAME,
  output logic                      RX_HOLD_TILL_END,
  output logic                      GROUP_FILTER_OK,
  output logic [4:0]                TX_ATTEMPT_LIMIT,
  output logic                      TX_FORCE_CLASH,
  output logic [5:0]                LOOP_TX_MAX,
  output logic [5:0]                LOOP_RX_MAX,
  output logic [5:0]                LOOP_MIN
);
  import ibf_pkg::*;

  // --------------------------------------------------------------------------
  // Fetch sequencer
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    IBF_IDLE,
    IBF_READ,
    IBF_DONE
  } ibf_state_t;

  ibf_state_t   state;
  ibf_state_t   next_state;
  logic [3:0]   word_idx;
  logic [3:0]   next_word_idx;
  logic [23:0]  rd_addr;
  logic [23:0]  next_rd_addr;
  logic [15:0]  mode_word;
  logic [15:0]  next_mode_word;
  ibf_params_t  params;
  ibf_params_t  next_params;
  logic         done_flag;
  logic         next_done_flag;
  logic         tx_run;
  logic         next_tx_run;
  logic         rx_run;
  logic         next_rx_run;

  always_comb begin
    next_state     = state;
    next_word_idx  = word_idx;
    next_rd_addr   = rd_addr;
    next_mode_word = mode_word;
    next_params    = params;
    next_done_flag = done_flag;
    next_tx_run    = tx_run;
    next_rx_run    = rx_run;
    // Clear first so a completion in the same cycle still wins
    if (DONE_CLEAR) begin
      next_done_flag = 1'b0;
    end
    case (state)
      IBF_IDLE: begin
        if (SETUP_REQ) begin
          next_state    = IBF_READ;
          next_word_idx = IDX_MODE;
          next_rd_addr  = {PARAM_BASE_HIGH_REG, PARAM_BASE_LOW_REG[15:1], 1'b0};
        end
      end
      IBF_READ: begin
        if (DMA_ACK) begin
          // Each word lands in its slot; address steps one word upward
          case (word_idx)
            IDX_MODE:      next_mode_word = DMA_RDATA & MODE_KEEP_MASK;
            4'h1:          next_params.station_address[15:0]  = DMA_RDATA;
            4'h2:          next_params.station_address[31:16] = DMA_RDATA;
            4'h3:          next_params.station_address[47:32] = DMA_RDATA;
            IDX_HASH:      next_params.group_hash_mask[15:0]  = DMA_RDATA;
            4'h5:          next_params.group_hash_mask[31:16] = DMA_RDATA;
            4'h6:          next_params.group_hash_mask[47:32] = DMA_RDATA;
            4'h7:          next_params.group_hash_mask[63:48] = DMA_RDATA;
            IDX_RX_RING:   next_params.rx_ring_base[15:0]     = DMA_RDATA;
            4'h9:          next_params.rx_ring_base[31:16]    = DMA_RDATA;
            IDX_TX_RING:   next_params.tx_ring_base[15:0]     = DMA_RDATA;
            default:       next_params.tx_ring_base[31:16]    = DMA_RDATA;
          endcase
          next_rd_addr  = rd_addr + WORD_STEP;
          next_word_idx = word_idx + 4'h1;
          if (word_idx == IDX_LAST) begin
            next_state     = IBF_DONE;
            next_done_flag = 1'b1;
            // Running flags follow run request but are cleared by the off bits
            next_tx_run    = RUN_REQ & ~mode_word[MB_TX_OFF];
            next_rx_run    = RUN_REQ & ~mode_word[MB_RX_OFF];
          end
        end
      end
      IBF_DONE: begin
        if (RUN_REQ) begin
          next_tx_run = ~mode_word[MB_TX_OFF];
          next_rx_run = ~mode_word[MB_RX_OFF];
        end
      end
      default: begin
        next_state = IBF_IDLE;
      end
    endcase
    // Stop clears mode and running state; parameters persist
    if (STOP_CMD) begin
      next_state     = IBF_IDLE;
      next_mode_word = MODE_RESET;
      next_done_flag = 1'b0;
      next_tx_run    = 1'b0;
      next_rx_run    = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state     <= IBF_IDLE;
      word_idx  <= IDX_MODE;
      rd_addr   <= 24'h000000;
      mode_word <= MODE_RESET;
      params    <= '0;
      done_flag <= 1'b0;
      tx_run    <= 1'b0;
      rx_run    <= 1'b0;
    end else begin
      state     <= next_state;
      word_idx  <= next_word_idx;
      rd_addr   <= next_rd_addr;
      mode_word <= next_mode_word;
      params    <= next_params;
      done_flag <= next_done_flag;
      tx_run    <= next_tx_run;
      rx_run    <= next_rx_run;
    end
  end

  // --------------------------------------------------------------------------
  // Mode decode, frozen until the fetch completes
  // --------------------------------------------------------------------------
  logic        active;
  logic [15:0] eff_mode;
  logic        loop_on;
  logic        wrap_in;
  ibf_loop_t   loop_sel;

  // Half-fetched words never leak into MODE; OPERATING_MODE_WORD and PARAMS follow each word
  assign active   = (state == IBF_DONE);
  assign eff_mode = active ? mode_word : MODE_RESET;
  assign loop_on  = eff_mode[MB_LOOP];
  assign wrap_in  = eff_mode[MB_WRAP_INSIDE];

  always_comb begin
    if (!loop_on) begin
      loop_sel = LOOP_NONE;
    end else if (wrap_in) begin
      loop_sel = LOOP_INTERNAL;
    end else begin
      loop_sel = LOOP_EXTERNAL;
    end
  end

  assign OPERATING_MODE_WORD = mode_word & MODE_KEEP_MASK;
  assign MODE.accept_all         = eff_mode[MB_ACCEPT_ALL];
  assign MODE.alt_backoff_enable = eff_mode[MB_ALT_BACKOFF];
  assign MODE.loop_sel           = loop_sel;
  assign MODE.single_attempt     = eff_mode[MB_SINGLE_TRY];
  assign MODE.force_clash        = eff_mode[MB_FORCE_CLASH];
  assign MODE.fcs_gen_off        = eff_mode[MB_FCS_GEN_OFF];
  assign MODE.transmitter_off    = eff_mode[MB_TX_OFF];
  assign MODE.receiver_off       = eff_mode[MB_RX_OFF];
  assign PARAMS                  = params;

  // --------------------------------------------------------------------------
  // Datapath controls
  // --------------------------------------------------------------------------
  assign RX_ACCEPT_ALL   = MODE.accept_all & ~MODE.receiver_off;
  assign RX_NET_ENABLE   = active & rx_run & (loop_sel != LOOP_INTERNAL);
  assign TX_TO_RX_WRAP   = (loop_sel == LOOP_INTERNAL);
  assign TX_RING_ALLOWED = active & tx_run & ~MODE.transmitter_off;
  assign RX_RING_ALLOWED = active & rx_run & ~MODE.receiver_off;

  // Shared CRC logic: generator or checker, never both
  assign TX_CRC_APPEND = ~MODE.fcs_gen_off | TX_APPEND_FCS;
  assign RX_CRC_CHECK  = MODE.fcs_gen_off & ~TX_APPEND_FCS;
  assign GROUP_FILTER_OK = (loop_sel != LOOP_EXTERNAL) | MODE.fcs_gen_off;

  // Retry control
  assign TX_FORCE_CLASH   = MODE.force_clash & (loop_sel == LOOP_INTERNAL);
  assign TX_ATTEMPT_LIMIT = MODE.single_attempt ? SINGLE_ATTEMPTS : NORMAL_ATTEMPTS;

  // Loopback size limits and FIFO discipline
  assign RX_SHORT_FILTER    = ~loop_on;
  assign LOOP_MIN           = LOOP_MIN_BYTES;
  assign LOOP_TX_MAX        = LOOP_MAX_BYTES;
  assign LOOP_RX_MAX        = TX_CRC_APPEND ? LOOP_RX_MAX_BYTES : LOOP_MAX_BYTES;
  assign TX_WAIT_FULL_FRAME = loop_on;
  assign RX_HOLD_TILL_END   = loop_on;

  // --------------------------------------------------------------------------
  // Status and bus outputs
  // --------------------------------------------------------------------------
  assign DMA_REQ.req         = (state == IBF_READ);
  assign DMA_REQ.addr        = rd_addr;
  assign SETUP_DONE_FLAG     = done_flag;
  assign IRQ_N               = ~(done_flag & IRQ_ENABLE);
  assign SETUP_BUSY          = (state == IBF_READ);
  assign TRANSMITTER_RUNNING = tx_run;
  assign RECEIVER_RUNNING    = rx_run;
endmodule // ibf_fetch

// ---- logic/ibf_pkg.sv ----
// Package for the parameter-block fetch and mode control block.
// Assumes a 16-bit word-wide bus-master memory port and one 50 MHz clock.
package ibf_pkg;
  // --------------------------------------------------------------------------
  // Parameter block layout (byte offsets and word indices from the block base)
  // --------------------------------------------------------------------------
  localparam int unsigned BLOCK_WORDS   = 12;
  localparam logic [4:0]  OFS_MODE      = 5'h00;
  localparam logic [4:0]  OFS_STATION   = 5'h02;
  localparam logic [4:0]  OFS_HASH      = 5'h08;
  localparam logic [4:0]  OFS_RX_RING   = 5'h10;
  localparam logic [4:0]  OFS_TX_RING   = 5'h14;
  localparam logic [3:0]  IDX_MODE      = 4'h0;
  localparam logic [3:0]  IDX_STATION   = 4'h1;
  localparam logic [3:0]  IDX_HASH      = 4'h4;
  localparam logic [3:0]  IDX_RX_RING   = 4'h8;
  localparam logic [3:0]  IDX_TX_RING   = 4'hA;
  localparam logic [3:0]  IDX_LAST      = 4'hB;
  localparam logic [23:0] WORD_STEP     = 24'h000002;

  // --------------------------------------------------------------------------
  // Operating mode word fields
  // --------------------------------------------------------------------------
  localparam int unsigned MB_ACCEPT_ALL   = 15;
  localparam int unsigned MB_ALT_BACKOFF  = 7;
  localparam int unsigned MB_WRAP_INSIDE  = 6;
  localparam int unsigned MB_SINGLE_TRY   = 5;
  localparam int unsigned MB_FORCE_CLASH  = 4;
  localparam int unsigned MB_FCS_GEN_OFF  = 3;
  localparam int unsigned MB_LOOP         = 2;
  localparam int unsigned MB_TX_OFF       = 1;
  localparam int unsigned MB_RX_OFF       = 0;
  localparam logic [15:0] MODE_KEEP_MASK  = 16'h80FF;
  localparam logic [15:0] MODE_RESET      = 16'h0000;

  // --------------------------------------------------------------------------
  // Register offsets of the operating mode word
  // --------------------------------------------------------------------------
  localparam logic [4:0]  OPERATING_MODE_WORD_OFS = 5'h00;

  // --------------------------------------------------------------------------
  // Transmit descriptor and loopback figures
  // --------------------------------------------------------------------------
  localparam int unsigned TXD1_APPEND_FCS   = 13;
  localparam logic [5:0]  LOOP_MIN_BYTES    = 6'd8;
  localparam logic [5:0]  LOOP_MAX_BYTES    = 6'd32;
  localparam logic [5:0]  LOOP_RX_MAX_BYTES = 6'd36;
  localparam logic [6:0]  SHORT_FRAME_BYTES = 7'd64;
  localparam logic [4:0]  NORMAL_ATTEMPTS   = 5'd16;
  localparam logic [4:0]  SINGLE_ATTEMPTS   = 5'd1;

  typedef enum logic [1:0] {
    LOOP_NONE,
    LOOP_EXTERNAL,
    LOOP_INTERNAL
  } ibf_loop_t;

  // Decoded mode as seen by the transmitter and receiver
  typedef struct packed {
    logic       accept_all;
    logic       alt_backoff_enable;
    ibf_loop_t  loop_sel;
    logic       single_attempt;
    logic       force_clash;
    logic       fcs_gen_off;
    logic       transmitter_off;
    logic       receiver_off;
  } ibf_mode_t;

  // Ring pointers and filters captured from the block
  typedef struct packed {
    logic [47:0] station_address;
    logic [63:0] group_hash_mask;
    logic [31:0] rx_ring_base;
    logic [31:0] tx_ring_base;
  } ibf_params_t;

  // Word-wide bus-master read request
  typedef struct packed {
    logic        req;
    logic [23:0] addr;
  } ibf_dma_req_t;
endpackage : ibf_pkg

// ---- bench/ibf_fetch_checker.sv ----
// Assertions on the ports of the parameter-block fetch block.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
module ibf_fetch_checker
  import ibf_pkg::*;
(
  input wire logic                  CORE_CLK,
  input wire logic                  RST_N,
  input wire logic                  STOP_CMD,
  input wire logic                  IRQ_ENABLE,
  input wire ibf_pkg::ibf_dma_req_t DMA_REQ,
  input wire logic                  DMA_ACK,
  input wire logic [15:0]           OPERATING_MODE_WORD,
  input wire ibf_pkg::ibf_mode_t    MODE,
  input wire logic                  SETUP_DONE_FLAG,
  input wire logic                  IRQ_N,
  input wire logic                  SETUP_BUSY,
  input wire logic                  TX_APPEND_FCS,
  input wire logic                  TX_CRC_APPEND,
  input wire logic                  RX_NET_ENABLE,
  input wire logic                  TX_TO_RX_WRAP,
  input wire logic [4:0]            TX_ATTEMPT_LIMIT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_step; (DMA_REQ.req && DMA_ACK && !STOP_CMD) ##1 DMA_REQ.req
    |-> DMA_REQ.addr == $past(DMA_REQ.addr) + 24'h000002; endproperty
  a_step: assert property (p_step) else $error("address step");
  property p_hold; DMA_REQ.req && !DMA_ACK && !STOP_CMD
    |=> DMA_REQ.req && $stable(DMA_REQ.addr); endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_done; $rose(SETUP_DONE_FLAG) |-> $past(DMA_ACK); endproperty
  a_done: assert property (p_done) else $error("done without word");
  property p_irq; IRQ_N == !(SETUP_DONE_FLAG && IRQ_ENABLE); endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_res; OPERATING_MODE_WORD[14:8] == 7'h00; endproperty
  a_res: assert property (p_res) else $error("reserved bits");
  property p_busy; SETUP_BUSY |-> MODE == ibf_mode_t'(0); endproperty
  a_busy: assert property (p_busy) else $error("mode early");
  property p_stop; STOP_CMD |=> !SETUP_DONE_FLAG && OPERATING_MODE_WORD == 16'h0000
    && !MODE.alt_backoff_enable; endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_wrap; TX_TO_RX_WRAP |-> MODE.loop_sel == LOOP_INTERNAL && !RX_NET_ENABLE;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_try; TX_ATTEMPT_LIMIT == (MODE.single_attempt ? 5'h01 : 5'h10); endproperty
  a_try: assert property (p_try) else $error("attempts");
  property p_crc; SETUP_DONE_FLAG |-> TX_CRC_APPEND == (!MODE.fcs_gen_off || TX_APPEND_FCS);
  endproperty
  a_crc: assert property (p_crc) else $error("tx crc");
endmodule // ibf_fetch_checker

bind ibf_fetch ibf_fetch_checker u_chk (
  .CORE_CLK, .RST_N, .STOP_CMD, .IRQ_ENABLE, .DMA_REQ, .DMA_ACK, .OPERATING_MODE_WORD,
  .MODE, .SETUP_DONE_FLAG, .IRQ_N, .SETUP_BUSY, .TX_APPEND_FCS, .TX_CRC_APPEND,
  .RX_NET_ENABLE, .TX_TO_RX_WRAP, .TX_ATTEMPT_LIMIT
);

// ---- bench/ibf_host_mem.sv ----
// Host memory model serving word reads of the parameter block.
// Assumes the bench loads word[] and supplies the block base and a stall line.
`timescale 1ns/1ps
module ibf_host_mem
  import ibf_pkg::*;
(
  input  wire logic                  CORE_CLK,
  input  wire ibf_pkg::ibf_dma_req_t DMA_REQ,
  input  wire logic [23:0]           base,
  input  wire logic                  stall,
  output logic                       DMA_ACK,
  output logic [15:0]                DMA_RDATA
);
  logic [15:0] word [12];
  logic [23:0] idx;
  logic        give;
  initial DMA_ACK = 1'b0;
  initial DMA_RDATA = 16'h0000;
  assign idx = (DMA_REQ.addr - base) >> 1;
  assign give = DMA_REQ.req && !DMA_ACK && !stall;
  // Off-answer cycles invert the previous cycle's data, so a stale read never passes
  always @(posedge CORE_CLK) begin
    DMA_ACK <= give;
    DMA_RDATA <= (give && idx < 24'd12) ? word[idx[3:0]] : ~DMA_RDATA;
  end
endmodule // ibf_host_mem

// ---- bench/init_block_fetch_mode_control_bench.sv ----
// Self-checking bench for the parameter-block fetch block.
// Assumes the host memory model and the bound checker are compiled before it.
`timescale 1ns/1ps
module init_block_fetch_mode_control_bench;
  import ibf_pkg::*;
  typedef struct {logic [15:0] mode; ibf_params_t prm; logic [14:0] flags; logic [32:0] ctl;}
    ibf_note_t;
  logic CORE_CLK = 1'b0, RST_N = 1'b0, STOP_CMD = 1'b0, SETUP_REQ = 1'b0, RUN_REQ = 1'b0;
  logic IRQ_ENABLE = 1'b0, DONE_CLEAR = 1'b0, TX_APPEND_FCS = 1'b0, stall = 1'b0;
  logic slow = 1'b0, was_done = 1'b0, DMA_ACK, SETUP_DONE_FLAG, IRQ_N, SETUP_BUSY;
  logic [15:0] PARAM_BASE_LOW_REG = 16'h0000, DMA_RDATA, OPERATING_MODE_WORD;
  logic [7:0] PARAM_BASE_HIGH_REG = 8'h00;
  ibf_dma_req_t DMA_REQ;
  ibf_mode_t MODE;
  ibf_params_t PARAMS;
  logic TRANSMITTER_RUNNING, RECEIVER_RUNNING, TX_RING_ALLOWED, RX_RING_ALLOWED;
  logic TX_CRC_APPEND, RX_CRC_CHECK, RX_NET_ENABLE, TX_TO_RX_WRAP, RX_ACCEPT_ALL;
  logic RX_SHORT_FILTER, TX_WAIT_FULL_FRAME, RX_HOLD_TILL_END, GROUP_FILTER_OK, TX_FORCE_CLASH;
  logic [4:0] TX_ATTEMPT_LIMIT;
  logic [5:0] LOOP_TX_MAX, LOOP_RX_MAX, LOOP_MIN;
  int seed = 78, fails = 0, comparisons = 0, cycles = 0;
  ibf_note_t notes[$];
  ibf_note_t n;
  // Zero mode first, then reserved bits, each loop kind, clash, single try, both off
  logic [15:0] modes [8] = '{16'h0000, 16'hFF80, 16'h0004, 16'h0044, 16'h0054, 16'h0014,
                             16'h0028, 16'h0003};
  ibf_fetch DUT (.CORE_CLK, .RST_N, .STOP_CMD, .SETUP_REQ, .RUN_REQ, .IRQ_ENABLE, .DONE_CLEAR,
    .PARAM_BASE_LOW_REG, .PARAM_BASE_HIGH_REG, .DMA_REQ, .DMA_ACK, .DMA_RDATA,
    .OPERATING_MODE_WORD, .MODE, .PARAMS, .SETUP_DONE_FLAG, .IRQ_N, .SETUP_BUSY,
    .TRANSMITTER_RUNNING, .RECEIVER_RUNNING, .TX_RING_ALLOWED, .RX_RING_ALLOWED,
    .TX_APPEND_FCS, .TX_CRC_APPEND, .RX_CRC_CHECK, .RX_NET_ENABLE, .TX_TO_RX_WRAP,
    .RX_ACCEPT_ALL, .RX_SHORT_FILTER, .TX_WAIT_FULL_FRAME, .RX_HOLD_TILL_END,
    .GROUP_FILTER_OK, .TX_ATTEMPT_LIMIT, .TX_FORCE_CLASH, .LOOP_TX_MAX, .LOOP_RX_MAX,
    .LOOP_MIN);
  // Odd low base bits are offered on purpose; the fetch must start at the even word
  ibf_host_mem host (.CORE_CLK, .DMA_REQ, .base({PARAM_BASE_HIGH_REG,
    PARAM_BASE_LOW_REG[15:1], 1'b0}), .stall, .DMA_ACK, .DMA_RDATA);
  always #10 CORE_CLK = ~CORE_CLK;
  always @(negedge CORE_CLK) stall <= slow & 1'($random(seed));
  task automatic check(input string what, input logic [175:0] seen, input logic [175:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(negedge CORE_CLK) begin
    if (SETUP_DONE_FLAG === 1'b1 && !was_done && notes.size() > 0) begin
      n = notes.pop_front();
      check("mode", OPERATING_MODE_WORD, n.mode);
      check("params", PARAMS, n.prm);
      check("flags", {TRANSMITTER_RUNNING, RECEIVER_RUNNING, IRQ_N, RX_NET_ENABLE,
        TX_TO_RX_WRAP, RX_ACCEPT_ALL, RX_SHORT_FILTER, TX_FORCE_CLASH, TX_CRC_APPEND,
        RX_CRC_CHECK, TX_ATTEMPT_LIMIT}, n.flags);
      check("ctl", {GROUP_FILTER_OK, TX_RING_ALLOWED, RX_RING_ALLOWED, TX_WAIT_FULL_FRAME,
        RX_HOLD_TILL_END, LOOP_MIN, LOOP_TX_MAX, LOOP_RX_MAX, MODE}, n.ctl);
    end
    was_done <= SETUP_DONE_FLAG;
  end
  task automatic run_setup(input logic [15:0] m);
    ibf_note_t e;
    logic lp;
    logic in;
    int k;
    @(negedge CORE_CLK);
    host.word[0] = m;
    for (k = 1; k < 12; k++)
      host.word[k] = 16'($random(seed));
    PARAM_BASE_LOW_REG = 16'($random(seed));
    PARAM_BASE_HIGH_REG = 8'($random(seed));
    IRQ_ENABLE = 1'($random(seed));
    TX_APPEND_FCS = 1'($random(seed));
    slow = 1'($random(seed));
    lp = m[2];
    in = m[2] & m[6];
    e.mode = m & 16'h80FF;
    e.prm = {host.word[3], host.word[2], host.word[1], host.word[7], host.word[6],
      host.word[5], host.word[4], host.word[9], host.word[8], host.word[11], host.word[10]};
    RUN_REQ = 1'($random(seed));
    e.flags = {RUN_REQ & ~m[1], RUN_REQ & ~m[0], ~IRQ_ENABLE, RUN_REQ & ~in & ~m[0], in,
      m[15] & ~m[0], ~lp, m[4] & in, ~m[3] | TX_APPEND_FCS, m[3] & ~TX_APPEND_FCS,
      m[5] ? 5'h01 : 5'h10};
    // Receive size limit grows by the CRC whenever the transmitter appends one
    e.ctl = {~(lp & ~m[6]) | m[3], RUN_REQ & ~m[1], RUN_REQ & ~m[0], lp, lp,
      LOOP_MIN_BYTES, LOOP_MAX_BYTES,
      (~m[3] | TX_APPEND_FCS) ? LOOP_RX_MAX_BYTES : LOOP_MAX_BYTES,
      m[15], m[7], lp ? (in ? LOOP_INTERNAL : LOOP_EXTERNAL) : LOOP_NONE,
      m[5], m[4], m[3], m[1], m[0]};
    notes.push_back(e);
    SETUP_REQ = 1'b1;
    @(negedge CORE_CLK);
    SETUP_REQ = 1'b0;
    for (k = 0; k < 300 && SETUP_DONE_FLAG !== 1'b1; k++)
      @(negedge CORE_CLK);
    check("done", SETUP_DONE_FLAG, 1'b1);
    SETUP_REQ = 1'b1;
    @(negedge CORE_CLK);
    SETUP_REQ = 1'b0;
    check("refused", {SETUP_BUSY, DMA_REQ.req}, 2'b00);
    DONE_CLEAR = 1'b1;
    @(negedge CORE_CLK);
    DONE_CLEAR = 1'b0;
    check("cleared", {SETUP_DONE_FLAG, IRQ_N}, 2'b01);
    STOP_CMD = 1'b1;
    @(negedge CORE_CLK);
    STOP_CMD = 1'b0;
    check("stopped", {OPERATING_MODE_WORD, TRANSMITTER_RUNNING, RECEIVER_RUNNING},
      18'h00000);
  endtask
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(negedge CORE_CLK);
    check("reset", {SETUP_DONE_FLAG, IRQ_N, DMA_REQ.req, OPERATING_MODE_WORD},
      19'h20000);
    RST_N = 1'b1;
    foreach (modes[i])
      run_setup(modes[i]);
    repeat (4)
      run_setup(16'($random(seed)));
    wrap_up();
  end
endmodule // init_block_fetch_mode_control_bench
